/* File: hdl/sfwc_ctrl.sv */
/*
 * Serial control and supervision of a twelve-channel switch: command
 * shift register, fault readback, watchdog and failsafe, fault flag.
 * Assumes link pins, reset pin, wake, watchdog feed and strap come from
 * outside ref_clk's domain; fault inputs come from same-clock logic.
 * Link clock half period must span at least four ref_clk cycles.
 */
`timescale 1ns/1ps
`include "sfwc_defines.svh"

module sfwc_ctrl
    import sfwc_pkg::*;
#(
    parameter int WDOG_CYCLES = `SFWC_WDOG_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       chip_select_n,
    input  wire logic       reset_n_input,
    input  wire logic       wake,
    input  wire logic       watchdog_feed_input,
    input  wire logic       failsafe_strap_input,
    input  wire sfwc_chan_t fault_in,
    output sfwc_pins_s      pins,
    output sfwc_chan_t      outputs,
    output logic            standby,
    output logic            failsafe_active
);

    localparam int WD_W = $clog2(WDOG_CYCLES + 1);

    // two-flop synchronisers, one per pin, first stage read only by second
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    // select and link clock reset to idle high: no false select or edge
    localparam logic [NSYNC-1:0] SYNC_IDLE = `SFWC_SYNC_IDLE;

    assign pin_raw = {sclk, mosi, chip_select_n, reset_n_input, wake,
                      watchdog_feed_input, failsafe_strap_input};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_q[gi] <= SYNC_IDLE[gi];
                    sync2_q[gi] <= SYNC_IDLE[gi];
                    prev_q[gi]  <= SYNC_IDLE[gi];
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    sfwc_link_s link;
    logic       rst_pin;
    logic       wake_s;
    logic       feed_s;
    logic       strap_s;

    assign link    = sfwc_link_s'(sync2_q[6:4]);
    assign rst_pin = sync2_q[3];
    assign wake_s  = sync2_q[2];
    assign feed_s  = sync2_q[1];
    assign strap_s = sync2_q[0];

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic rst_rise;
    logic wake_rise;
    logic feed_edge;
    logic selected;

    assign sclk_rise = link.sclk & ~prev_q[6];
    assign sclk_fall = ~link.sclk & prev_q[6];
    // edge detectors start from SYNC_IDLE; the reset pin starts low, so a high pin gives one rise
    assign cs_fall   = ~link.cs_n & prev_q[4];
    assign cs_rise   = link.cs_n & ~prev_q[4];
    assign rst_rise  = rst_pin & ~prev_q[3];
    assign wake_rise = wake_s & ~prev_q[2];
    assign feed_edge = feed_s ^ prev_q[1];
    assign selected  = ~link.cs_n;

    // low-current standby; outputs are cleared through cmd_q
    // standby follows the reset pin
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            standby <= 1'b1;
        end else begin
            standby <= ~rst_pin;
        end
    end

    // fault register: sticky per channel, cleared only by the reset pin
    // fault_in is same-clock logic and needs no synchroniser
    sfwc_chan_t fault_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= `SFWC_FAULT_RESET;
        end else if (!rst_pin) begin
            fault_q <= `SFWC_FAULT_RESET;
        end else begin
            fault_q <= fault_q | fault_in;
        end
    end

    // serial port
    logic [`SFWC_FRAME_BITS-1:0] rx_q;
    logic [`SFWC_FRAME_BITS-1:0] tx_q;
    logic [`SFWC_CNT_W-1:0]      bits_q;
    logic                        miso_q;
    logic                        sampled_q;
    logic                        frame_ok;
    assign frame_ok = (bits_q == `SFWC_CNT_W'(`SFWC_FRAME_BITS));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_q <= '0;
        end else if (cs_fall) begin
            rx_q <= '0;
        end else if (selected && sclk_fall) begin
            rx_q <= {rx_q[`SFWC_FRAME_BITS-2:0], link.mosi};
        end
    end

    // saturates, so a long frame still counts as sixteen bits
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bits_q <= '0;
        end else if (cs_fall) begin
            bits_q <= '0;
        end else if (selected && sclk_fall && !frame_ok) begin
            bits_q <= bits_q + `SFWC_CNT_W'(1);
        end
    end

    // response frame: upper four bits zero, faults 11..0 below
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= '0;
        end else if (cs_fall) begin
            tx_q <= {4'h0, fault_q | fault_in};
        end else if (selected && sclk_rise && sampled_q) begin
            tx_q <= {tx_q[`SFWC_FRAME_BITS-2:0], 1'b0};
        end
    end

    // set by the first fall; the first rise after it already shifts and presents bit 14
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sampled_q <= 1'b0;
        end else if (cs_fall) begin
            sampled_q <= 1'b0;
        end else if (selected && sclk_fall) begin
            sampled_q <= 1'b1;
        end
    end

    // shows the msb from select fall until the first shifting rise
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            miso_q <= 1'b0;
        end else if (cs_fall) begin
            miso_q <= 1'b0; // top bit of frame is always zero
        end else if (selected && sclk_rise && sampled_q) begin
            miso_q <= tx_q[`SFWC_FRAME_BITS-2];
        end
    end

    // command register; a short frame is dropped
    sfwc_chan_t cmd_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q <= `SFWC_CMD_RESET;
        end else if (!rst_pin) begin
            cmd_q <= `SFWC_CMD_RESET;
        end else if (cs_rise && frame_ok) begin
            cmd_q <= rx_q[`SFWC_LS_MSB:`SFWC_HS_LSB];
        end
    end

    // watchdog
    sfwc_wd_e        wd_q;
    logic [WD_W-1:0] wd_cnt_q;
    logic            wd_off;
    logic            wd_kick;
    logic            wd_expired;

    // wake restarts a running count as well as starting an idle one
    assign wd_off     = !rst_pin || !strap_s;
    assign wd_kick    = feed_edge || wake_rise;
    assign wd_expired = (wd_cnt_q == WD_W'(WDOG_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_q <= SFWC_WD_OFF;
        end else if (wd_off) begin
            wd_q <= SFWC_WD_OFF;
        end else begin
            unique case (wd_q)
                SFWC_WD_OFF: begin
                    if (rst_rise || wake_rise) begin
                        wd_q <= SFWC_WD_RUN;
                    end
                end
                SFWC_WD_RUN: begin
                    if (!wd_kick && wd_expired) begin
                        wd_q <= SFWC_WD_FAILSAFE;
                    end
                end
                // left only through the reset pin or the strap
                SFWC_WD_FAILSAFE: begin
                    wd_q <= SFWC_WD_FAILSAFE;
                end
                default: begin
                    wd_q <= SFWC_WD_OFF;
                end
            endcase
        end
    end

    // counts only while running, so every start begins from zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_cnt_q <= '0;
        end else if (wd_off || wd_q != SFWC_WD_RUN || wd_kick) begin
            wd_cnt_q <= '0;
        end else if (!wd_expired) begin
            wd_cnt_q <= wd_cnt_q + WD_W'(1);
        end
    end

    // outputs from flops; failsafe forces high-side a and c on
    sfwc_chan_t fs_mask;
    always_comb begin
        fs_mask                 = '0;
        fs_mask[`SFWC_HS_A_BIT] = 1'b1;
        fs_mask[`SFWC_HS_C_BIT] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            outputs <= '0;
        end else if (wd_q == SFWC_WD_FAILSAFE) begin
            outputs <= cmd_q | fs_mask;
        end else begin
            outputs <= cmd_q;
        end
    end

    // mirrors the watchdog state a cycle late, in step with outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            failsafe_active <= 1'b0;
        end else begin
            failsafe_active <= (wd_q == SFWC_WD_FAILSAFE);
        end
    end

    // fault flag, open drain: pull low while any fault is stored
    logic fault_any_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_any_q <= 1'b0;
        end else begin
            fault_any_q <= |fault_q;
        end
    end

    // miso_oe is a combinational enable from the synchronised select
    always_comb begin
        pins.fault_o  = 1'b0;
        pins.fault_oe = fault_any_q;
        pins.miso_o   = miso_q;
        pins.miso_oe  = selected;
    end

endmodule

/* File: hdl/sfwc_defines.svh */
/*
 * Constants of the serial switch supervisor: frame size, channel map,
 * watchdog timing and reset values.
 * Assumes a 125 MHz ref_clk; included by bare name.
 */
`ifndef SFWC_DEFINES_SVH
`define SFWC_DEFINES_SVH

`define SFWC_FRAME_BITS      16
`define SFWC_CHANNELS        12
`define SFWC_HS_LSB          0
`define SFWC_HS_MSB          3
`define SFWC_LS_LSB          4
`define SFWC_LS_MSB          11
`define SFWC_HS_A_BIT        0
`define SFWC_HS_C_BIT        2
`define SFWC_CLK_PERIOD_NS   8
`define SFWC_WDOG_TIMEOUT_US 10000
`define SFWC_WDOG_CYCLES     ((`SFWC_WDOG_TIMEOUT_US * 1000) / `SFWC_CLK_PERIOD_NS)
`define SFWC_CMD_RESET       12'h000
`define SFWC_FAULT_RESET     12'h000
`define SFWC_CNT_W           5
`define SFWC_SYNC_IDLE       7'h50

`endif

/* File: hdl/sfwc_pkg.sv */
/*
 * Types of the serial switch supervisor.
 * Assumes sfwc_defines.svh is on the include path.
 */
`include "sfwc_defines.svh"

package sfwc_pkg;

    typedef logic [`SFWC_CHANNELS-1:0] sfwc_chan_t;

    typedef enum logic [2:0] {
        SFWC_WD_OFF      = 3'b001,
        SFWC_WD_RUN      = 3'b010,
        SFWC_WD_FAILSAFE = 3'b100
    } sfwc_wd_e;

    // pins of the serial link after synchronisation
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic cs_n;
    } sfwc_link_s;

    // open-drain fault flag and tri-state serial out, as two signals each
    typedef struct packed {
        logic miso_o;
        logic miso_oe;
        logic fault_o;
        logic fault_oe;
    } sfwc_pins_s;

endpackage

/* File: test/sfwc_ctrl_assertions.sv */
/* port assertions of sfwc_ctrl.
   bound into sfwc_ctrl; single ref_clk domain. */
`timescale 1ns/1ps
module sfwc_ctrl_assertions
    import sfwc_pkg::*;
(
    input logic       ref_clk,
    input logic       reset_n,
    input logic       sclk,
    input logic       chip_select_n,
    input logic       reset_n_input,
    input logic       failsafe_strap_input,
    input sfwc_chan_t fault_in,
    input sfwc_pins_s pins,
    input sfwc_chan_t outputs,
    input logic       standby,
    input logic       failsafe_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // repeat counts leave room for the pin synchronisers
    property p_float; chip_select_n [*4] |-> !pins.miso_oe; endproperty
    a_float: assert property (p_float) else $error("miso not released");
    property p_drive; !chip_select_n [*4] |-> pins.miso_oe; endproperty
    a_drive: assert property (p_drive) else $error("miso not driven");
    property p_rise; pins.miso_oe && $past(pins.miso_oe) && $changed(pins.miso_o) |-> sclk;
    endproperty
    a_rise: assert property (p_rise) else $error("miso moved off rise");
    property p_stby; !reset_n_input [*5] |-> standby && outputs == 12'h000; endproperty
    a_stby: assert property (p_stby) else $error("no standby");
    property p_run; reset_n_input [*6] |-> !standby; endproperty
    a_run: assert property (p_run) else $error("stuck in standby");
    property p_flag; reset_n_input [*6] ##0 (|fault_in) |-> ##2 pins.fault_oe && !pins.fault_o;
    endproperty
    a_flag: assert property (p_flag) else $error("fault flag late");
    property p_fsoff; !failsafe_strap_input [*5] |-> !failsafe_active; endproperty
    a_fsoff: assert property (p_fsoff) else $error("failsafe with strap low");
    property p_fsout; failsafe_active [*2] ##0 reset_n_input |-> outputs[0] && outputs[2];
    endproperty
    a_fsout: assert property (p_fsout) else $error("failsafe outputs off");
endmodule

bind sfwc_ctrl sfwc_ctrl_assertions u_sfwc_ctrl_assertions (.ref_clk, .reset_n, .sclk,
    .chip_select_n, .reset_n_input, .failsafe_strap_input, .fault_in, .pins, .outputs,
    .standby, .failsafe_active);

/* File: test/sfwc_ctrl_tb.sv */
/* bench of sfwc_ctrl with the spi master model.
   watchdog cut to 50 cycles; link clock 125 ns. */
`timescale 1ns/1ps
module sfwc_ctrl_tb;
    import sfwc_pkg::*;
    localparam int WD = 50;
    logic        ref_clk, reset_n, miso, miso_last, feed_en, sclk, mosi, chip_select_n;
    logic        reset_n_input, wake, watchdog_feed_input, failsafe_strap_input;
    logic        standby, failsafe_active;
    sfwc_chan_t  fault_in, outputs;
    sfwc_pins_s  pins;
    logic [15:0] rx;
    int          num_errors, total_checks, cycles;

    sfwc_ctrl #(.WDOG_CYCLES(WD)) u_sfwc_ctrl (.ref_clk, .reset_n, .sclk, .mosi,
        .chip_select_n, .reset_n_input, .wake, .watchdog_feed_input, .failsafe_strap_input,
        .fault_in, .pins, .outputs, .standby, .failsafe_active);
    sfwc_master u_sfwc_master (.sclk, .mosi, .chip_select_n, .miso);
    // released line shows the inverse of its last driven bit
    assign miso = pins.miso_oe ? pins.miso_o : ~miso_last;
    always @(posedge ref_clk) begin
        if (!reset_n) miso_last <= 1'b0;
        else if (pins.miso_oe) miso_last <= pins.miso_o;
    end
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        cycles++;
        if (!reset_n) watchdog_feed_input = 1'b0;
        else if (feed_en && cycles % 20 == 0) watchdog_feed_input = ~watchdog_feed_input;
        if (cycles == 6000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic frame(input logic [15:0] tx, input int n);
        u_sfwc_master.xfer(tx, n, rx);
        tick(6);
    endtask
    task automatic t_cmd;
        fault_in = 12'h801;
        tick(4);
        check(16'(pins.fault_oe), 16'h0001);
        frame(16'hFA5C, 16);
        check(16'(outputs), 16'h0A5C);
        check(rx, 16'h0801);
        check(16'(pins.miso_oe), 16'h0000);
        fault_in = 12'h000;
        frame(16'h0FFF, 15);
        check(16'(outputs), 16'h0A5C);
        $display("t_cmd end");
    endtask
    task automatic t_wdog;
        tick(3 * WD);
        check(16'(failsafe_active), 16'h0000);
        feed_en = 1'b0;
        tick(WD + 12);
        check(16'(failsafe_active), 16'h0001);
        check(16'(outputs), 16'h0A5D);
        frame(16'h0010, 16);
        check(16'(outputs), 16'h0015);
        reset_n_input = 1'b0;
        tick(10);
        check(16'(standby), 16'h0001);
        reset_n_input = 1'b1;
        tick(6);
        feed_en = 1'b1;
        check(16'(failsafe_active), 16'h0000);
        frame(16'h0010, 16);
        check(rx, 16'h0000);
        check(16'(outputs), 16'h0010);
        $display("t_wdog end");
    endtask
    task automatic t_strap;
        failsafe_strap_input = 1'b0;
        feed_en = 1'b0;
        tick(WD + 12);
        check(16'(failsafe_active), 16'h0000);
        failsafe_strap_input = 1'b1;
        tick(4);
        wake = 1'b1;
        tick(WD + 12);
        check(16'(failsafe_active), 16'h0001);
        $display("t_strap end");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        reset_n_input = 1'b1;
        wake = 1'b0;
        failsafe_strap_input = 1'b1;
        fault_in = 12'h000;
        feed_en = 1'b0;
        tick(20);
        reset_n = 1'b1;
        feed_en = 1'b1;
        tick(10);
        t_cmd();
        t_wdog();
        t_strap();
        report_and_stop();
    end
endmodule

/* File: test/sfwc_master.sv */
/* spi master model: sclk idle high, bit valid at each fall.
   own delays, unrelated to ref_clk. */
`timescale 1ns/1ps
module sfwc_master (
    output logic sclk,
    output logic mosi,
    output logic chip_select_n,
    input  logic miso
);
    initial {sclk, mosi, chip_select_n} = 3'b101;
    // n under 16 makes a frame the device must drop
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        chip_select_n = 1'b0;
        #62.5;
        for (int i = 15; i > 15 - n; i--) begin
            mosi = tx[i];
            #31.25 rx[i] = miso;
            sclk = 1'b0;
            #62.5 sclk = 1'b1;
            #31.25;
        end
        mosi = 1'b0;
        #31.25 chip_select_n = 1'b1;
        #250;
    endtask
endmodule
